// ==== verilog/cbsc_regs.vh ====
// Constants of the clock buffer serial configuration slave
`ifndef CBSC_REGS_VH
`define CBSC_REGS_VH
`define CBSC_SLAVE_ADDR 7'h69
`define CBSC_CMD_CODE 8'h00
`define CBSC_CFG0_IDX 2'h0
`define CBSC_CFG1_IDX 2'h1
`define CBSC_CFG2_IDX 2'h2
`define CBSC_CFG0_RST 8'h0F
`define CBSC_CFG1_RST 8'hF0
`define CBSC_CFG2_RST 8'hC0
`define CBSC_CFG0_EN_LSB 0
`define CBSC_CFG0_EN_MSB 3
`define CBSC_CFG1_EN_LSB 4
`define CBSC_CFG1_EN_MSB 7
`define CBSC_CFG2_EN_LSB 6
`define CBSC_CFG2_EN_MSB 7
`define CBSC_MAX_COUNT 8'h20
`define CBSC_STRETCH_LIMIT_MS 10
// Cycles at 50 MHz the data line may stay low, minus one
`define CBSC_HOLD_LIMIT_CYC 20'h7A11F
`endif

// ==== verilog/cbsc_sync.v ====
// Two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module cbsc_sync #(
  parameter RESET_VAL = 1'b1
) (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_b_in,
  // Level
  input wire async_in,
  output wire sync_out
);
  reg meta_r;
  reg sync_r;

  // Second stage is the only reader of the first
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule // cbsc_sync

// ==== verilog/cbsc_top.v ====
// Serial configuration slave gating ten fanout clock outputs
`timescale 1ns/1ps
`include "cbsc_regs.vh"
module cbsc_top #(
  parameter NUM_CFG_BYTES = 3
) (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_b_in,
  // Serial bus pins (open drain)
  input wire serial_clock_line_in,
  input wire serial_data_line_in,
  output wire serial_data_line_out,
  output wire serial_data_line_oe_out,
  // Power state
  input wire low_power_state_in,
  // Reference clock to be fanned out
  input wire ref_clock_in,
  // Fanout clock outputs
  output wire fanout_clock_zero_out,
  output wire fanout_clock_one_out,
  output wire fanout_clock_two_out,
  output wire fanout_clock_three_out,
  output wire fanout_clock_twelve_out,
  output wire fanout_clock_thirteen_out,
  output wire fanout_clock_fourteen_out,
  output wire fanout_clock_fifteen_out,
  output wire fanout_clock_sixteen_out,
  output wire fanout_clock_seventeen_out,
  // Stored configuration bytes
  output wire [7:0] output_enable_low_group_out,
  output wire [7:0] output_enable_high_group_out,
  output wire [7:0] output_enable_optional_group_out
);
  // Receive states
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ACK = 3'h2;
  localparam ST_CMD = 3'h3;
  localparam ST_CNT = 3'h4;
  localparam ST_DATA = 3'h5;
  localparam ST_SKIP = 3'h6;

  // Pin levels after synchronisation and their delayed copies
  wire scl_s;
  wire sda_s;
  reg scl_d_r;
  reg sda_d_r;

  // Receive state, shift register and counters
  reg [2:0] state_r;
  reg [2:0] after_ack_r;
  reg [7:0] shift_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] count_r;
  reg [1:0] byte_idx_r;
  reg ack_drv_r;
  reg [7:0] shifted;

  // Stored configuration bytes and their enable fields
  reg [7:0] cfg0_r;
  reg [7:0] cfg1_r;
  reg [7:0] cfg2_r;
  wire [3:0] low_en;
  wire [3:0] high_en;
  wire [1:0] opt_en;

  // Bus events and write strobes
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire byte_end;
  wire addr_match;
  wire store_en;

  // Data line hold watchdog
  reg [19:0] hold_cnt_r;
  wire hold_expired;

  // Synchronise pins; no glitch filter
  cbsc_sync #(.RESET_VAL(1'b1)) u_sync_scl (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .async_in(serial_clock_line_in),
    .sync_out(scl_s)
  );
  cbsc_sync #(.RESET_VAL(1'b1)) u_sync_sda (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .async_in(serial_data_line_in),
    .sync_out(sda_s)
  );

  // Delayed copies for edge and condition detection
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // Own address with write direction; general call never matches
  assign addr_match = (shift_r == {`CBSC_SLAVE_ADDR, 1'b0});
  // Eighth bit done; a data byte is kept only within count and size
  assign byte_end = scl_fall && (bit_cnt_r == 4'h8);
  assign store_en = ~low_power_state_in & ~hold_expired & ~start_det &
    ~stop_det & byte_end & (state_r == ST_DATA) & (count_r != 8'h00) &
    (byte_idx_r < NUM_CFG_BYTES);

  // Counts cycles with the data line pulled low
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hold_cnt_r <= 20'h00000;
    end else if (ack_drv_r) begin
      hold_cnt_r <= hold_cnt_r + 20'h00001;
    end else begin
      hold_cnt_r <= 20'h00000;
    end
  end

  // Stalled controller: line given back within 10 ms
  assign hold_expired = (hold_cnt_r == `CBSC_HOLD_LIMIT_CYC);

  // Bits arrive most significant first
  always @* begin
    shifted = {shift_r[6:0], sda_s};
  end

  // Configuration bytes in ascending slots; untouched in low power
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg0_r <= `CBSC_CFG0_RST;
      cfg1_r <= `CBSC_CFG1_RST;
      cfg2_r <= `CBSC_CFG2_RST;
    end else if (store_en) begin
      case (byte_idx_r)
        `CBSC_CFG0_IDX: cfg0_r <= shift_r;
        `CBSC_CFG1_IDX: cfg1_r <= shift_r;
        default: cfg2_r <= shift_r;
      endcase
    end
  end

  // Receive state machine; never stretches the clock
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= ST_IDLE;
      after_ack_r <= ST_IDLE;
      shift_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      count_r <= 8'h00;
      byte_idx_r <= 2'h0;
      ack_drv_r <= 1'b0;
    end else if (low_power_state_in) begin
      // Release the bus, keep configuration
      state_r <= ST_IDLE;
      ack_drv_r <= 1'b0;
    end else if (hold_expired) begin
      // Stalled mid acknowledge: release, wait for START
      state_r <= ST_IDLE;
      ack_drv_r <= 1'b0;
    end else if (start_det) begin
      state_r <= ST_ADDR;
      bit_cnt_r <= 4'h0;
      byte_idx_r <= 2'h0;
      ack_drv_r <= 1'b0;
    end else if (stop_det) begin
      state_r <= ST_IDLE;
      ack_drv_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          ack_drv_r <= 1'b0;
        end
        ST_ADDR, ST_CMD, ST_CNT, ST_DATA: begin
          if (scl_rise) begin
            shift_r <= shifted;
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (byte_end) begin
            bit_cnt_r <= 4'h0;
            case (state_r)
              ST_ADDR: begin
                // Own address with write only; general call
                // and reads are ignored
                if (addr_match) begin
                  ack_drv_r <= 1'b1;
                  state_r <= ST_ACK;
                  after_ack_r <= ST_CMD;
                end else begin
                  state_r <= ST_IDLE;
                end
              end
              ST_CMD: begin
                // Command code contents ignored
                ack_drv_r <= 1'b1;
                state_r <= ST_ACK;
                after_ack_r <= ST_CNT;
              end
              ST_CNT: begin
                // Count kept; data valid after this ack
                count_r <= shift_r;
                ack_drv_r <= 1'b1;
                state_r <= ST_ACK;
                after_ack_r <= ST_DATA;
              end
              default: begin
                // Next byte slot on every kept byte
                if (store_en) begin
                  byte_idx_r <= byte_idx_r + 2'h1;
                end
                if (count_r != 8'h00) begin
                  count_r <= count_r - 8'h01;
                end
                ack_drv_r <= 1'b1;
                state_r <= ST_ACK;
                after_ack_r <= ST_DATA;
              end
            endcase
          end
        end
        ST_ACK: begin
          // Hold acknowledge through the ninth clock pulse
          if (scl_rise) begin
            state_r <= ST_SKIP;
          end
        end
        ST_SKIP: begin
          // Release once the ninth clock pulse has fallen
          if (scl_fall) begin
            ack_drv_r <= 1'b0;
            state_r <= after_ack_r;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Open drain: only ever pulls low, never sends data
  assign serial_data_line_out = 1'b0;
  assign serial_data_line_oe_out = ack_drv_r & ~low_power_state_in;

  // Enable fields of the three bytes
  assign low_en = cfg0_r[`CBSC_CFG0_EN_MSB:`CBSC_CFG0_EN_LSB];
  assign high_en = cfg1_r[`CBSC_CFG1_EN_MSB:`CBSC_CFG1_EN_LSB];
  assign opt_en = cfg2_r[`CBSC_CFG2_EN_MSB:`CBSC_CFG2_EN_LSB];

  // Output gating; unused bits reach no fanout clock output
  assign fanout_clock_zero_out = ref_clock_in & low_en[0];
  assign fanout_clock_one_out = ref_clock_in & low_en[1];
  assign fanout_clock_two_out = ref_clock_in & low_en[2];
  assign fanout_clock_three_out = ref_clock_in & low_en[3];
  assign fanout_clock_twelve_out = ref_clock_in & high_en[0];
  assign fanout_clock_thirteen_out = ref_clock_in & high_en[1];
  assign fanout_clock_fourteen_out = ref_clock_in & high_en[2];
  assign fanout_clock_fifteen_out = ref_clock_in & high_en[3];
  assign fanout_clock_sixteen_out = ref_clock_in & opt_en[0];
  assign fanout_clock_seventeen_out = ref_clock_in & opt_en[1];

  // Stored bytes for observation
  assign output_enable_low_group_out = cfg0_r;
  assign output_enable_high_group_out = cfg1_r;
  assign output_enable_optional_group_out = cfg2_r;
endmodule // cbsc_top

// ==== sim/cbsc_checker.sv ====
// Port-level assertions for the serial configuration slave
`timescale 1ns/1ps
module cbsc_checker (
  // Clock, reset and bus pins
  input logic clk_sys_in, rst_b_in, low_power_state_in, ref_clock_in,
  input logic serial_data_line_out, serial_data_line_oe_out,
  // Fanout clocks
  input logic fanout_clock_zero_out, fanout_clock_one_out,
  input logic fanout_clock_two_out, fanout_clock_three_out,
  input logic fanout_clock_twelve_out, fanout_clock_thirteen_out,
  input logic fanout_clock_fourteen_out, fanout_clock_fifteen_out,
  input logic fanout_clock_sixteen_out, fanout_clock_seventeen_out,
  // Stored configuration
  input logic [7:0] output_enable_low_group_out,
  input logic [7:0] output_enable_high_group_out,
  input logic [7:0] output_enable_optional_group_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  // Configuration bytes viewed together
  wire [23:0] cfg = {output_enable_low_group_out,
    output_enable_high_group_out, output_enable_optional_group_out};
  wire r = ref_clock_in;
  data_out_zero_a: assert property (serial_data_line_out == 1'b0)
    else $error("data pin driven high");
  lp_release_a: assert property ((low_power_state_in ||
    $fell(low_power_state_in)) |-> !serial_data_line_oe_out)
    else $error("bus held in low power");
  lp_keep_a: assert property (low_power_state_in |=> $stable(cfg))
    else $error("config changed in low power");
  low_map_a: assert property ({fanout_clock_three_out,
    fanout_clock_two_out, fanout_clock_one_out, fanout_clock_zero_out} ==
    ({4{r}} & cfg[19:16])) else $error("low group gating wrong");
  high_map_a: assert property ({fanout_clock_fifteen_out,
    fanout_clock_fourteen_out, fanout_clock_thirteen_out,
    fanout_clock_twelve_out} == ({4{r}} & cfg[15:12]))
    else $error("high group gating wrong");
  opt_map_a: assert property ({fanout_clock_seventeen_out,
    fanout_clock_sixteen_out} == ({2{r}} & cfg[7:6]))
    else $error("optional group gating wrong");
  stretch_bound_a: assert property ($rose(serial_data_line_oe_out)
    |-> ##[1:1000] !serial_data_line_oe_out)
    else $error("data held low too long");
  cfg_with_ack_a: assert property (!$stable(cfg) |->
    serial_data_line_oe_out) else $error("config changed without ack");
  // Main scenarios reached
  cover property ($rose(serial_data_line_oe_out));
  cover property (!$stable(cfg));
  cover property (low_power_state_in);
endmodule // cbsc_checker
bind cbsc_top cbsc_checker i_chk (.*);

// ==== sim/cbsc_host_model.sv ====
// Serial bus controller model issuing block writes
`timescale 1ns/1ps
module cbsc_host_model (
  // Clock and bus level
  input wire clk_in,
  input wire sda_in,
  // Driven lines
  output logic scl_out,
  output logic sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Wait whole cycles; a half bit is eight of them
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic half(input logic v);
    scl_out <= v;
    tick(8);
  endtask
  // Data falls while the clock is high
  task automatic start;
    sda_low_out <= 1'b1;
    tick(8);
    half(1'b0);
  endtask
  // Bits go most significant first, then the line is freed for the ack
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low_out <= ~b[i];
      tick(2);
      half(1'b1);
      half(1'b0);
    end
    sda_low_out <= 1'b0;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    ack = sda_in;
    tick(4);
    half(1'b0);
  endtask
  // Data rises while the clock is high
  task automatic stop;
    sda_low_out <= 1'b1;
    tick(2);
    half(1'b1);
    sda_low_out <= 1'b0;
    tick(8);
  endtask
endmodule // cbsc_host_model

// ==== sim/tb_top.sv ====
// Testbench for the serial configuration slave
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic lp = 1'b0;
  logic ref_clk = 1'b0;
  logic aa, nak;
  wire scl, sda_low, sda_oe;
  wire sda = ~(sda_low | sda_oe); // Pull-up wired-AND
  wire [7:0] g0, g1, g2;
  int n_errors = 0;
  int cmp_count = 0;
  always #10 clk_sys_in = ~clk_sys_in;
  // Reference clock toggles each cycle
  always @(posedge clk_sys_in) ref_clk <= ~ref_clk;
  cbsc_host_model i_host (.clk_in(clk_sys_in), .sda_in(sda),
    .scl_out(scl), .sda_low_out(sda_low));
  cbsc_top i_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .serial_clock_line_in(scl), .serial_data_line_in(sda),
    .serial_data_line_out(), .serial_data_line_oe_out(sda_oe),
    .low_power_state_in(lp), .ref_clock_in(ref_clk),
    .fanout_clock_zero_out(), .fanout_clock_one_out(),
    .fanout_clock_two_out(), .fanout_clock_three_out(),
    .fanout_clock_twelve_out(), .fanout_clock_thirteen_out(),
    .fanout_clock_fourteen_out(), .fanout_clock_fifteen_out(),
    .fanout_clock_sixteen_out(), .fanout_clock_seventeen_out(),
    .output_enable_low_group_out(g0), .output_enable_high_group_out(g1),
    .output_enable_optional_group_out(g2));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Block write: address, zero command, count, data; stop after an address nack
  task automatic blk(input logic [7:0] adr, input logic [7:0] cnt,
    input int nd, input logic [23:0] d);
    logic ak;
    nak = 1'b0;
    i_host.start();
    i_host.wbyte(adr, aa);
    if (aa === 1'b0) begin
      i_host.wbyte(8'h00, ak);
      nak = nak | ak;
      i_host.wbyte(cnt, ak);
      nak = nak | ak;
      for (int i = 0; i < nd; i++) begin
        i_host.wbyte(d[23-8*i -: 8], ak);
        nak = nak | ak;
      end
    end
    i_host.stop();
  endtask
  task automatic t_reset;
    chk(g0, 8'h0F);
    chk(g1, 8'hF0);
    chk(g2, 8'hC0);
    $display("test reset done");
  endtask
  task automatic t_full;
    blk(8'hD2, 8'h03, 3, 24'h05A040);
    chk({7'h00, aa}, 8'h00);
    chk({7'h00, nak}, 8'h00);
    chk(g0, 8'h05);
    chk(g1, 8'hA0);
    chk(g2, 8'h40);
    $display("test full write done");
  endtask
  task automatic t_short;
    blk(8'hD2, 8'h01, 2, 24'h0EF000);
    chk({7'h00, nak}, 8'h00);
    chk(g0, 8'h0E);
    chk(g1, 8'hA0);
    $display("test short count done");
  endtask
  task automatic t_refuse;
    logic [7:0] adrs [3] = '{8'hD4, 8'hD3, 8'h00};
    foreach (adrs[k]) begin
      blk(adrs[k], 8'h01, 1, 24'hFF0000);
      chk({7'h00, aa}, 8'h01);
      chk(g0, 8'h0E);
    end
    lp <= 1'b1;
    blk(8'hD2, 8'h01, 1, 24'h000000);
    chk({7'h00, aa}, 8'h01);
    chk(g0, 8'h0E);
    lp <= 1'b0;
    $display("test refusals done");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Reset for two cycles, then the scenarios
  initial begin
    repeat (2) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    t_reset();
    t_full();
    t_short();
    t_refuse();
    report_and_stop();
  end
endmodule // tb_top
